/* src/chain_ctrl_pkg.sv */
// Package for the descriptor chain control block: register map, fields, status layout.
// Assumes a 32-bit Avalon-MM slave whose addresses are the byte offsets themselves.
package chain_ctrl_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned PTR_W  = 16;

  localparam logic [ADDR_W-1:0] OFS_RESTART  = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_STEP     = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_CANCEL   = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_START    = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_CURRENT  = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 6'h34;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h38;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 6'h3C;

  localparam int unsigned CTRL_BIT      = 0;
  localparam int unsigned STAT_WAIT_BIT = 6;
  localparam int unsigned STAT_ABORT_BIT = 8;

  localparam logic [PTR_W-1:0] START_PTR_RST = 16'h0000;
  localparam logic [31:0]      UNMAPPED_DATA = 32'h0000_0000;

  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_WAIT  = 0;
  localparam int unsigned IRQ_ABORT = 1;
  localparam int unsigned IRQ_RESET = 2;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_RUN,
    SEQ_WAIT,
    SEQ_ABORT
  } seq_state_e;

  typedef struct packed {
    logic             seq_reset;
    logic             advance;
    logic             abort_start;
    logic [PTR_W-1:0] start_ptr;
  } seq_ctrl_s;

  typedef struct packed {
    logic waiting;
    logic aborting;
  } seq_stat_s;

endpackage

/* src/toggle_strobe.sv */
// Falling-edge strobe on a stored control bit.
// Assumes the bit is a register on the same clock.
`timescale 1ns/1ps
`default_nettype none
module toggle_strobe
(
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic bit_in,
  output logic      strobe
);
  logic prev_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      prev_q <= 1'b0;
    else
      prev_q <= bit_in;
  end

  // Only the one-to-zero transition acts, so a bit left high does nothing more.
  assign strobe = prev_q & ~bit_in;
endmodule
`default_nettype wire

/* src/sticky_irq.sv */
// Sticky interrupt flags with enable mask and write-one clear.
// Assumes events and clear pulses come from the same clock.
`timescale 1ns/1ps
`default_nettype none
module sticky_irq
#(
  parameter int unsigned W = 3
)
(
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [W-1:0] event_in,
  input  wire logic [W-1:0] clear_in,
  input  wire logic [W-1:0] enable_in,
  output logic      [W-1:0] status,
  output logic              irq
);
  logic [W-1:0] flag_q;
  logic [W-1:0] flag_d;

  // Set wins over clear so an event in the clearing cycle is kept.
  assign flag_d = (flag_q & ~clear_in) | event_in;
  assign status = flag_q;
  assign irq    = |(flag_q & enable_in);

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      flag_q <= '0;
    else
      flag_q <= flag_d;
  end
endmodule
`default_nettype wire

/* src/dma_chain_control.sv */
// Control registers and chain sequencer gate of a stream-to-host DMA engine.
// Assumes an Avalon-MM master on clk_sys and an engine reporting link and drain events.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - A one-then-zero write on restart bit 0 at 0x00 resets the chain sequencer.
// - After a sequencer reset the first link starts only on an advance toggle at 0x04.
// - A later link in manual mode waits until advance is toggled again.
// - A pending manual link is shown by a readable waiting flag.
// - The first advance after reset fetches the link at the start pointer.
// - A one-then-zero write on abort bit 0 at 0x08 starts an abort sequence.
// - During abort built packets still go out but no new transfer starts.
// - When all built packets are out the abort ends in a self-made sequencer reset.
// - The 16-bit start pointer at 0x0C bits 15:0 resets to zero and is read/write.
// - Status bit 6 reads one while a manual link awaits advance.
// - Status bit 8 reads one from abort start until abort completes.
// - After a reset the current link address is loaded from the start pointer.
module dma_chain_control
(
  input  wire logic                              clk_sys,
  input  wire logic                              rstn,
  input  wire logic [chain_ctrl_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                              avs_read,
  input  wire logic                              avs_write,
  input  wire logic [31:0]                       avs_writedata,
  input  wire logic [3:0]                        avs_byteenable,
  output logic      [31:0]                       avs_readdata,
  output logic                                   avs_waitrequest,
  input  wire logic                              link_done,
  input  wire logic                              next_manual,
  input  wire logic                              chain_end,
  input  wire logic [chain_ctrl_pkg::PTR_W-1:0]  next_ptr,
  input  wire logic                              packets_pending,
  output logic                                   seq_reset,
  output logic                                   link_start,
  output logic      [chain_ctrl_pkg::PTR_W-1:0]  link_ptr,
  output logic                                   new_activity_en,
  output logic                                   waiting,
  output logic                                   aborting,
  output logic                                   irq
);
  chain_ctrl_pkg::seq_state_e state_q;
  chain_ctrl_pkg::seq_state_e state_d;

  logic                             restart_q;
  logic                             step_q;
  logic                             cancel_q;
  logic [chain_ctrl_pkg::PTR_W-1:0] start_ptr_q;
  logic [chain_ctrl_pkg::PTR_W-1:0] cur_ptr_q;
  logic [chain_ctrl_pkg::PTR_W-1:0] cur_ptr_d;
  logic                             ack_q;
  logic [31:0]                      rdata_q;
  logic [31:0]                      rdata_d;
  logic [chain_ctrl_pkg::IRQ_W-1:0] irq_en_q;
  logic [chain_ctrl_pkg::IRQ_W-1:0] irq_status;
  logic [chain_ctrl_pkg::IRQ_W-1:0] irq_clear;
  logic [chain_ctrl_pkg::IRQ_W-1:0] irq_event;
  logic                             restart_stb;
  logic                             step_stb;
  logic                             cancel_stb;
  logic                             abort_done;
  logic                             link_start_d;
  logic                             seq_reset_d;
  logic                             seq_reset_q;
  logic                             link_start_q;
  chain_ctrl_pkg::seq_stat_s        stat;

  // One wait cycle per access keeps read data registered.
  wire req      = avs_read | avs_write;
  // A write lands only at the edge where waitrequest is seen low, as the master expects.
  wire wr_fire  = avs_write & ack_q;
  wire rd_fire  = avs_read & ~ack_q;
  wire be0      = avs_byteenable[0];
  wire be1      = avs_byteenable[1];
  wire sel_rst  = wr_fire & be0 & (avs_address == chain_ctrl_pkg::OFS_RESTART);
  wire sel_step = wr_fire & be0 & (avs_address == chain_ctrl_pkg::OFS_STEP);
  wire sel_can  = wr_fire & be0 & (avs_address == chain_ctrl_pkg::OFS_CANCEL);
  wire sel_ptr  = wr_fire & (avs_address == chain_ctrl_pkg::OFS_START);
  wire sel_ien  = wr_fire & be0 & (avs_address == chain_ctrl_pkg::OFS_IRQ_EN);
  wire sel_iclr = wr_fire & be0 & (avs_address == chain_ctrl_pkg::OFS_IRQ_CLR);

  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;

  // Only bit 0 of each control word is stored, so the rest stay zero.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      restart_q   <= 1'b0;
      step_q      <= 1'b0;
      cancel_q    <= 1'b0;
      start_ptr_q <= chain_ctrl_pkg::START_PTR_RST;
      irq_en_q    <= '0;
      ack_q       <= 1'b0;
      rdata_q     <= '0;
    end
    else
    begin
      ack_q   <= req & ~ack_q;
      rdata_q <= rdata_d;
      if (sel_rst)
        restart_q <= avs_writedata[chain_ctrl_pkg::CTRL_BIT];
      if (sel_step)
        step_q <= avs_writedata[chain_ctrl_pkg::CTRL_BIT];
      if (sel_can)
        cancel_q <= avs_writedata[chain_ctrl_pkg::CTRL_BIT];
      if (sel_ptr && be0)
        start_ptr_q[7:0] <= avs_writedata[7:0];
      if (sel_ptr && be1)
        start_ptr_q[15:8] <= avs_writedata[15:8];
      if (sel_ien)
        irq_en_q <= avs_writedata[chain_ctrl_pkg::IRQ_W-1:0];
    end
  end

  assign irq_clear = sel_iclr ? avs_writedata[chain_ctrl_pkg::IRQ_W-1:0] : '0;

  always_comb
  begin
    rdata_d = chain_ctrl_pkg::UNMAPPED_DATA;
    if (rd_fire)
    begin
      unique case (avs_address)
        chain_ctrl_pkg::OFS_RESTART:  rdata_d = {31'h0, restart_q};
        chain_ctrl_pkg::OFS_STEP:     rdata_d = {31'h0, step_q};
        chain_ctrl_pkg::OFS_CANCEL:   rdata_d = {31'h0, cancel_q};
        chain_ctrl_pkg::OFS_START:    rdata_d = {16'h0, start_ptr_q};
        chain_ctrl_pkg::OFS_STATUS:
        begin
          rdata_d[chain_ctrl_pkg::STAT_WAIT_BIT]  = stat.waiting;
          rdata_d[chain_ctrl_pkg::STAT_ABORT_BIT] = stat.aborting;
        end
        chain_ctrl_pkg::OFS_CURRENT:  rdata_d = {16'h0, cur_ptr_q};
        chain_ctrl_pkg::OFS_IRQ_EN:   rdata_d = {29'h0, irq_en_q};
        chain_ctrl_pkg::OFS_IRQ_STAT: rdata_d = {29'h0, irq_status};
        default:                      rdata_d = chain_ctrl_pkg::UNMAPPED_DATA;
      endcase
    end
  end

  toggle_strobe u_restart
  (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .bit_in  (restart_q),
    .strobe  (restart_stb)
  );

  toggle_strobe u_step
  (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .bit_in  (step_q),
    .strobe  (step_stb)
  );

  toggle_strobe u_cancel
  (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .bit_in  (cancel_q),
    .strobe  (cancel_stb)
  );

  // Abort finishes once the engine has no built packet left to send.
  assign abort_done = (state_q == chain_ctrl_pkg::SEQ_ABORT) & ~packets_pending;

  always_comb
  begin
    state_d      = state_q;
    cur_ptr_d    = cur_ptr_q;
    link_start_d = 1'b0;
    seq_reset_d  = 1'b0;
    if (restart_stb || abort_done)
    begin
      // Both the software restart and the end of an abort reset the sequencer.
      state_d     = chain_ctrl_pkg::SEQ_IDLE;
      seq_reset_d = 1'b1;
      cur_ptr_d   = start_ptr_q;
    end
    else if (cancel_stb && state_q != chain_ctrl_pkg::SEQ_ABORT)
    begin
      state_d = chain_ctrl_pkg::SEQ_ABORT;
    end
    else
    begin
      unique case (state_q)
        chain_ctrl_pkg::SEQ_IDLE:
        begin
          if (step_stb)
          begin
            // The first link always needs an advance, auto or manual.
            state_d      = chain_ctrl_pkg::SEQ_RUN;
            cur_ptr_d    = start_ptr_q;
            link_start_d = 1'b1;
          end
        end
        chain_ctrl_pkg::SEQ_RUN:
        begin
          if (link_done)
          begin
            if (chain_end)
              state_d = chain_ctrl_pkg::SEQ_IDLE;
            else if (next_manual)
            begin
              state_d   = chain_ctrl_pkg::SEQ_WAIT;
              cur_ptr_d = next_ptr;
            end
            else
            begin
              cur_ptr_d    = next_ptr;
              link_start_d = 1'b1;
            end
          end
        end
        chain_ctrl_pkg::SEQ_WAIT:
        begin
          if (step_stb)
          begin
            state_d      = chain_ctrl_pkg::SEQ_RUN;
            link_start_d = 1'b1;
          end
        end
        chain_ctrl_pkg::SEQ_ABORT:
        begin
          state_d = chain_ctrl_pkg::SEQ_ABORT;
        end
      endcase
    end
  end

  // Chain end leaves the sequencer idle but not reset, so an advance alone starts the chain again at the start pointer.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state_q      <= chain_ctrl_pkg::SEQ_IDLE;
      cur_ptr_q    <= chain_ctrl_pkg::START_PTR_RST;
      seq_reset_q  <= 1'b0;
      link_start_q <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      cur_ptr_q    <= cur_ptr_d;
      seq_reset_q  <= seq_reset_d;
      link_start_q <= link_start_d;
    end
  end

  assign stat.waiting  = (state_q == chain_ctrl_pkg::SEQ_WAIT);
  assign stat.aborting = (state_q == chain_ctrl_pkg::SEQ_ABORT);

  assign seq_reset       = seq_reset_q;
  assign link_start      = link_start_q;
  assign link_ptr        = cur_ptr_q;
  assign waiting         = stat.waiting;
  assign aborting        = stat.aborting;
  assign new_activity_en = ~stat.aborting;

  assign irq_event[chain_ctrl_pkg::IRQ_WAIT]  = link_done & next_manual & ~chain_end &
                                                (state_q == chain_ctrl_pkg::SEQ_RUN);
  assign irq_event[chain_ctrl_pkg::IRQ_ABORT] = abort_done;
  assign irq_event[chain_ctrl_pkg::IRQ_RESET] = seq_reset_d;

  sticky_irq #(.W(chain_ctrl_pkg::IRQ_W)) u_irq
  (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .event_in  (irq_event),
    .clear_in  (irq_clear),
    .enable_in (irq_en_q),
    .status    (irq_status),
    .irq       (irq)
  );
endmodule
`default_nettype wire

/* sim/engine_model.sv */
// Engine model: reports finished links and unsent packets.
// Assumes the bench calls its tasks from the clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module engine_model
(
  input  wire logic                             clk_sys,
  output logic                                  link_done,
  output logic                                  next_manual,
  output logic                                  chain_end,
  output logic [chain_ctrl_pkg::PTR_W-1:0]      next_ptr,
  output logic                                  packets_pending
);
  initial
  begin
    link_done = 1'b0;
    next_manual = 1'b0;
    chain_end = 1'b0;
    next_ptr = 16'h0000;
    packets_pending = 1'b0;
  end
  // Link qualifiers are inverted once invalid, so stale values are never trusted.
  task automatic finish(input logic [15:0] p, input logic m, input logic e);
    @(posedge clk_sys);
    link_done <= 1'b1;
    next_manual <= m;
    chain_end <= e;
    next_ptr <= p;
    @(posedge clk_sys);
    link_done <= 1'b0;
    next_manual <= ~m;
    chain_end <= ~e;
    next_ptr <= ~p;
  endtask
  task automatic hold(input logic v);
    @(posedge clk_sys);
    packets_pending <= v;
  endtask
endmodule
`default_nettype wire

/* sim/dma_chain_control_props.sv */
// Checker on the ports of the chain control block.
// Assumes one clock domain and the synchronous reset rstn.
`timescale 1ns/1ps
`default_nettype none
module dma_chain_control_props
(
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        link_done,
  input wire logic        next_manual,
  input wire logic        chain_end,
  input wire logic [15:0] next_ptr,
  input wire logic        packets_pending,
  input wire logic        seq_reset,
  input wire logic        link_start,
  input wire logic [15:0] link_ptr,
  input wire logic        new_activity_en,
  input wire logic        waiting,
  input wire logic        aborting
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus wait too long");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address == 6'h10 |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rst_pulse;
    seq_reset |=> !seq_reset;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
  property p_go_pulse;
    link_start |=> !link_start;
  endproperty
  a_go_pulse: assert property (p_go_pulse) else $error("start pulse too long");
  property p_no_go_abort;
    aborting |-> !link_start && !new_activity_en;
  endproperty
  a_no_go_abort: assert property (p_no_go_abort) else $error("activity in abort");
  property p_drain;
    aborting && !packets_pending |-> ##[0:2] seq_reset;
  endproperty
  a_drain: assert property (p_drain) else $error("no reset after drain");
  property p_hold;
    aborting && packets_pending |=> aborting || seq_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("abort ended early");
  property p_after_rst;
    seq_reset |=> !aborting && !waiting;
  endproperty
  a_after_rst: assert property (p_after_rst) else $error("state kept over reset");
  property p_auto;
    link_done && !next_manual && !chain_end && new_activity_en && !waiting
      |=> link_start && link_ptr == $past(next_ptr);
  endproperty
  a_auto: assert property (p_auto) else $error("auto link not started");
  property p_manual;
    link_done && next_manual && !chain_end && new_activity_en |-> ##[1:2] waiting;
  endproperty
  a_manual: assert property (p_manual) else $error("manual link not waiting");
  c_go: cover property (link_start);
  c_wait: cover property (waiting);
  c_drain: cover property (aborting && !packets_pending);
endmodule
bind dma_chain_control dma_chain_control_props i_props
(
  .clk_sys, .rstn, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .link_done, .next_manual, .chain_end, .next_ptr,
  .packets_pending, .seq_reset, .link_start, .link_ptr, .new_activity_en,
  .waiting, .aborting
);
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the chain control block.
// Assumes the engine model stands in for the packet engine.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys, rstn, avs_read, avs_write, irq, seq_reset, link_start;
  logic new_activity_en, waiting, aborting, link_done, next_manual, chain_end;
  logic packets_pending, wreq;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [15:0] next_ptr, link_ptr;
  int mismatches, cmp_count, n_rst, n_go;
  engine_model i_eng (.clk_sys, .link_done, .next_manual, .chain_end, .next_ptr,
    .packets_pending);
  dma_chain_control i_dut (.clk_sys, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest(wreq),
    .link_done, .next_manual, .chain_end, .next_ptr, .packets_pending, .seq_reset,
    .link_start, .link_ptr, .new_activity_en, .waiting, .aborting, .irq);
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    if (seq_reset === 1'b1) n_rst++;
    if (link_start === 1'b1) n_go++;
  end
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Waitrequest is read right after the edge, which still shows the value sampled there.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (wreq !== 1'b0)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, wreq, 1'b0);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  task automatic tg(input logic [5:0] a);
    wr(a, 32'h1);
    wr(a, 32'h0);
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic t_regs;
    rd(chain_ctrl_pkg::OFS_START, 32'h0);
    wr(chain_ctrl_pkg::OFS_START, 32'hFFFF_ABCD);
    rd(chain_ctrl_pkg::OFS_START, 32'h0000_ABCD);
    wr(chain_ctrl_pkg::OFS_RESTART, 32'hFFFF_FFFF);
    rd(chain_ctrl_pkg::OFS_RESTART, 32'h1);
    rd(6'h10, 32'h0);
    check(n_rst, 0);
  endtask
  task automatic t_start;
    wr(chain_ctrl_pkg::OFS_START, 32'h1234);
    wr(chain_ctrl_pkg::OFS_RESTART, 32'h0);
    repeat (4) @(posedge clk_sys);
    check(n_rst, 1);
    check(32'(link_ptr), 32'h1234);
    check(n_go, 0);
    tg(chain_ctrl_pkg::OFS_STEP);
    check(n_go, 1);
    check(32'(link_ptr), 32'h1234);
  endtask
  task automatic t_links;
    i_eng.finish(16'h0042, 1'b0, 1'b0);
    repeat (3) @(posedge clk_sys);
    check(n_go, 2);
    check(32'(link_ptr), 32'h0042);
    i_eng.finish(16'h0077, 1'b1, 1'b0);
    repeat (3) @(posedge clk_sys);
    check(32'(waiting), 32'h1);
    rd(chain_ctrl_pkg::OFS_STATUS, 32'h40);
    check(n_go, 2);
    tg(chain_ctrl_pkg::OFS_STEP);
    check(n_go, 3);
    check(32'(waiting), 32'h0);
    i_eng.finish(16'h0099, 1'b0, 1'b1);
    repeat (3) @(posedge clk_sys);
    check(n_go, 3);
  endtask
  task automatic t_abort;
    i_eng.hold(1'b1);
    tg(chain_ctrl_pkg::OFS_CANCEL);
    check(32'(aborting), 32'h1);
    check(32'(new_activity_en), 32'h0);
    rd(chain_ctrl_pkg::OFS_STATUS, 32'h100);
    check(n_rst, 1);
    i_eng.hold(1'b0);
    repeat (4) @(posedge clk_sys);
    check(n_rst, 2);
    check(32'(aborting), 32'h0);
    tg(chain_ctrl_pkg::OFS_RESTART);
    check(n_rst, 3);
  endtask
  task automatic t_irq;
    rd(chain_ctrl_pkg::OFS_IRQ_STAT, 32'h7);
    check(32'(irq), 32'h0);
    wr(chain_ctrl_pkg::OFS_IRQ_EN, 32'h7);
    rd(chain_ctrl_pkg::OFS_IRQ_EN, 32'h7);
    check(32'(irq), 32'h1);
    wr(chain_ctrl_pkg::OFS_IRQ_CLR, 32'h7);
    rd(chain_ctrl_pkg::OFS_IRQ_STAT, 32'h0);
    check(32'(irq), 32'h0);
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    stop_test();
  end
  initial
  begin
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs();
    t_start();
    t_links();
    t_abort();
    t_irq();
    stop_test();
  end
endmodule
`default_nettype wire
